// >>> src/flash_port_regs.svh
// timing and layout constants of the serial flash port
`ifndef FLASH_PORT_REGS_SVH
`define FLASH_PORT_REGS_SVH
// ----------------------------------------
// clock figures
// ----------------------------------------
`define SYS_CLK_PERIOD_PS   10000
`define LINK_CLK_PERIOD_PS  6000
`define FLASH_CLK_MIN_PS    27800
`define FLASH_CLK_MAX_PS    704000
// least half period rounds up, longest rounds down
`define HALF_MIN_CYC  ((`FLASH_CLK_MIN_PS + 2 * `LINK_CLK_PERIOD_PS - 1) / (2 * `LINK_CLK_PERIOD_PS))
`define HALF_MAX_CYC  (`FLASH_CLK_MAX_PS / (2 * `LINK_CLK_PERIOD_PS))
// ----------------------------------------
// frame layout
// ----------------------------------------
`define OPCODE_BITS   8
`define ADDR_BITS     24
`define DATA_BITS     32
`define SHIFT_BITS    64
`define CNT_RESET     8'h00
`endif

// >>> src/flash_port_pkg.sv
// types shared by the serial flash port
package flash_port_pkg;
   typedef struct packed {
      logic [7:0]  opcode;
      logic [23:0] address;
      logic        hasAddr;
      logic [31:0] wrData;
      logic [2:0]  wrBytes;
      logic [2:0]  rdBytes;
      logic [7:0]  halfDiv;
   } flash_cmd_t;
   typedef enum logic [1:0] {L_IDLE, L_LOW, L_HIGH, L_GAP} link_state_t;
endpackage : flash_port_pkg

// >>> src/serial_flash_port.sv
// serial flash port: command handshake on sys_clk, serial engine on the link clock
//
// Behaviour
// RL1: flash clock made here, half period programmable, clamped to 1.4-36.0 MHz range.
// RL2: 24-bit address covers flashes from one up to 128 megabits.
// RL3: each outgoing bit is launched on the falling flash clock edge.
// RL4: incoming bit sampled on the falling edge, tolerating slow flash outputs.
// RL5: data out and select change only together with falling clock edges.
// RL6: select held low through a whole transfer, high between transfers.
`timescale 1ns/100ps
`include "flash_port_regs.svh"
module serial_flash_port (
   // clocks and reset
   input  wire logic                       sys_clk,
   input  wire logic                       linkClk,
   input  wire logic                       rst_b,
   // command side
   input  wire logic                       cmdValid,
   input  wire flash_port_pkg::flash_cmd_t cmd,
   output logic                            cmdReady,
   output logic                            rdDone,
   output logic [31:0]                     rdData,
   // flash pins
   output logic                            flashClk,
   output logic                            flashSelectN,
   output logic                            flashDout,
   input  wire logic                       flashDin
);
   import flash_port_pkg::*;

   // ----------------------------------------
   // command side, sys_clk
   // ----------------------------------------
   flash_cmd_t  cmdHold_ff;
   logic        busy_ff;
   logic        ready_ff;
   logic        reqToggle_ff;
   logic        doneToggle_ff;
   logic [2:0]  doneSync_ff;
   logic        rdDone_ff;
   logic [31:0] rdData_ff;
   logic        doneEdge;
   logic [31:0] rxData_ff;

   assign doneEdge = doneSync_ff[2] ^ doneSync_ff[1];

   // the held command stays still while busy, so the link side may read it freely
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmdHold_ff   <= '0;
         busy_ff      <= 1'b0;
         ready_ff     <= 1'b1;
         reqToggle_ff <= 1'b0;
      end else if (cmdValid && !busy_ff) begin
         cmdHold_ff   <= cmd;
         busy_ff      <= 1'b1;
         ready_ff     <= 1'b0;
         reqToggle_ff <= ~reqToggle_ff;
      end else if (doneEdge) begin
         busy_ff      <= 1'b0;
         ready_ff     <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         doneSync_ff <= 3'h0;
         rdDone_ff   <= 1'b0;
         rdData_ff   <= 32'h0;
      end else begin
         doneSync_ff <= {doneSync_ff[1:0], doneToggle_ff};
         rdDone_ff   <= doneEdge;
         if (doneEdge) begin
            rdData_ff <= rxData_ff;
         end
      end
   end

   // a separate flop keeps the ready output free of logic after the register
   assign cmdReady = ready_ff;
   assign rdDone   = rdDone_ff;
   assign rdData   = rdData_ff;

   // ----------------------------------------
   // link side, linkClk
   // ----------------------------------------
   link_state_t        state_ff;
   logic [2:0]         reqSync_ff;
   logic [1:0]         dinSync_ff;
   logic [7:0]         cnt_ff;
   logic [7:0]         half_ff;
   logic [6:0]         bitsLeft_ff;
   logic [6:0]         rdBits_ff;
   logic [63:0]        shift_ff;
   logic               flashClk_ff;
   logic               flashSelectN_ff;
   logic               flashDout_ff;
   logic               start;
   logic [7:0]         halfClamp;
   logic [6:0]         totalBits;
   logic [63:0]        loadShift;

   assign start = reqSync_ff[2] ^ reqSync_ff[1];

   // slow clock rates need long half periods; the clamp keeps any setting inside the allowed band
   always_comb begin
      if (cmdHold_ff.halfDiv < 8'(`HALF_MIN_CYC)) begin
         halfClamp = 8'(`HALF_MIN_CYC); // RL1
      end else if (cmdHold_ff.halfDiv > 8'(`HALF_MAX_CYC)) begin
         halfClamp = 8'(`HALF_MAX_CYC); // RL1
      end else begin
         halfClamp = cmdHold_ff.halfDiv;
      end
   end

   always_comb begin
      totalBits = 7'(`OPCODE_BITS) + 7'({cmdHold_ff.wrBytes, 3'h0}) + 7'({cmdHold_ff.rdBytes, 3'h0});
      if (cmdHold_ff.hasAddr) begin
         totalBits = totalBits + 7'(`ADDR_BITS); // RL2
         loadShift = {cmdHold_ff.opcode, cmdHold_ff.address, cmdHold_ff.wrData};
      end else begin
         loadShift = {cmdHold_ff.opcode, cmdHold_ff.wrData, 24'h0};
      end
   end

   // request toggle and data pin both pass two flops before use
   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) begin
         reqSync_ff <= 3'h0;
         dinSync_ff <= 2'h0;
      end else begin
         reqSync_ff <= {reqSync_ff[1:0], reqToggle_ff};
         dinSync_ff <= {dinSync_ff[0], flashDin};
      end
   end

   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff        <= L_IDLE;
         cnt_ff          <= `CNT_RESET;
         half_ff         <= `CNT_RESET;
         bitsLeft_ff     <= 7'h00;
         rdBits_ff       <= 7'h00;
         shift_ff        <= 64'h0;
         rxData_ff       <= 32'h0;
         flashClk_ff     <= 1'b0;
         flashSelectN_ff <= 1'b1;
         flashDout_ff    <= 1'b0;
         doneToggle_ff   <= 1'b0;
      end else begin
         case (state_ff)
            L_IDLE: begin
               if (start) begin
                  // clock is idle low, so this counts as the launching falling edge
                  half_ff         <= halfClamp;
                  cnt_ff          <= halfClamp - 8'h01;
                  bitsLeft_ff     <= totalBits;
                  rdBits_ff       <= 7'({cmdHold_ff.rdBytes, 3'h0});
                  shift_ff        <= {loadShift[62:0], 1'b0};
                  flashDout_ff    <= loadShift[63]; // RL3
                  flashSelectN_ff <= 1'b0;          // RL6
                  rxData_ff       <= 32'h0;
                  state_ff        <= L_LOW;
               end
            end
            L_LOW: begin
               if (cnt_ff == 8'h00) begin
                  flashClk_ff <= 1'b1;
                  cnt_ff      <= half_ff - 8'h01;
                  state_ff    <= L_HIGH;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            L_HIGH: begin
               if (cnt_ff == 8'h00) begin
                  flashClk_ff <= 1'b0;
                  cnt_ff      <= half_ff - 8'h01;
                  bitsLeft_ff <= bitsLeft_ff - 7'h01;
                  if (bitsLeft_ff <= rdBits_ff) begin
                     rxData_ff <= {rxData_ff[30:0], dinSync_ff[1]}; // RL4
                  end
                  if (bitsLeft_ff == 7'h01) begin
                     flashSelectN_ff <= 1'b1; // RL5 RL6
                     flashDout_ff    <= 1'b0; // RL5
                     state_ff        <= L_GAP;
                  end else begin
                     flashDout_ff <= shift_ff[63]; // RL3 RL5
                     shift_ff     <= {shift_ff[62:0], 1'b0};
                     state_ff     <= L_LOW;
                  end
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            L_GAP: begin
               // one idle half period with select high before the next transfer
               if (cnt_ff == 8'h00) begin
                  doneToggle_ff <= ~doneToggle_ff;
                  state_ff      <= L_IDLE;
               end else begin
                  cnt_ff <= cnt_ff - 8'h01;
               end
            end
            default: begin
               state_ff <= L_IDLE;
            end
         endcase
      end
   end

   assign flashClk     = flashClk_ff;
   assign flashSelectN = flashSelectN_ff;
   assign flashDout    = flashDout_ff;
endmodule : serial_flash_port

// >>> test/serial_flash_port_asserts.sv
// checker for the serial flash port pins and handshake
`timescale 1ns/100ps
module serial_flash_port_chk (
   // clocks and reset
   input wire logic        sys_clk,
   input wire logic        linkClk,
   input wire logic        rst_b,
   // watched ports
   input wire logic        cmdValid,
   input wire logic        cmdReady,
   input wire logic        rdDone,
   input wire logic [31:0] rdData,
   input wire logic        flashClk,
   input wire logic        flashSelectN,
   input wire logic        flashDout
);
   logic [7:0] hiCnt_ff;
   // counts the high phase, too long for a repetition
   always_ff @(posedge linkClk or negedge rst_b) begin
      if (!rst_b) hiCnt_ff <= 8'h00;
      else hiCnt_ff <= flashClk ? hiCnt_ff + 8'h01 : 8'h00;
   end
   a_idle_clk_low: assert property (@(posedge linkClk) disable iff (!rst_b) flashSelectN |-> !flashClk)
      else $error("clock runs outside a frame");
   a_pins_hold_high: assert property (@(posedge linkClk) disable iff (!rst_b)
      flashClk |-> $stable(flashDout) && $stable(flashSelectN)) else $error("pin moved off a falling edge");
   a_high_min: assert property (@(posedge linkClk) disable iff (!rst_b) $rose(flashClk) |-> flashClk[*3])
      else $error("high phase too short");
   a_low_min: assert property (@(posedge linkClk) disable iff (!rst_b) $fell(flashClk) |-> !flashClk[*3])
      else $error("low phase too short");
   a_high_max: assert property (@(posedge linkClk) disable iff (!rst_b) hiCnt_ff <= 8'h3A)
      else $error("high phase too long");
   a_take_busy: assert property (@(posedge sys_clk) disable iff (!rst_b) cmdValid && cmdReady |=> !cmdReady)
      else $error("ready after take");
   a_done_ready: assert property (@(posedge sys_clk) disable iff (!rst_b) rdDone |-> cmdReady ##1 !rdDone)
      else $error("done not a pulse with ready");
   a_data_on_done: assert property (@(posedge sys_clk) disable iff (!rst_b) $changed(rdData) |-> rdDone)
      else $error("read data moved without done");
   c_frame: cover property (@(posedge linkClk) disable iff (!rst_b) $fell(flashSelectN));
   c_done: cover property (@(posedge sys_clk) disable iff (!rst_b) rdDone);
   c_refused: cover property (@(posedge sys_clk) disable iff (!rst_b) cmdValid && !cmdReady);
endmodule : serial_flash_port_chk
bind serial_flash_port serial_flash_port_chk u_chk (.sys_clk(sys_clk), .linkClk(linkClk), .rst_b(rst_b),
   .cmdValid(cmdValid), .cmdReady(cmdReady), .rdDone(rdDone), .rdData(rdData), .flashClk(flashClk),
   .flashSelectN(flashSelectN), .flashDout(flashDout));

// >>> test/flash_model.sv
// behavioural serial flash: captures the frame, answers a fixed pattern
`timescale 1ns/100ps
module flash_model #(parameter logic [31:0] PAT = 32'hC3A5_5A3C) (
   // flash pins
   input wire logic  flashClk,
   input wire logic  flashSelectN,
   input wire logic  flashDout,
   output logic      flashDin,
   // frame seen by the bench
   output logic [95:0] rxBits,
   output logic [6:0]  rxCnt
);
   logic [4:0] txIdx;
   initial flashDin = 1'b0;
   always @(negedge flashSelectN) begin
      txIdx = 5'h00;
      rxCnt = 7'h00;
      rxBits = '0;
      flashDin = PAT[31];
   end
   // bits taken on the rising edge
   always @(posedge flashClk) if (!flashSelectN) begin
      rxBits = {rxBits[94:0], flashDout};
      rxCnt = rxCnt + 7'h01;
   end
   // answers at the falling edge itself, with no added delay
   always @(negedge flashClk) if (!flashSelectN) begin
      txIdx = txIdx + 5'h01;
      flashDin = PAT[5'd31 - txIdx];
   end
   // no pull on the line: show a stale inverse once released
   always @(posedge flashSelectN) flashDin = ~flashDin;
endmodule : flash_model

// >>> test/serial_flash_port_tb.sv
// self-checking bench of the serial flash port
`timescale 1ns/100ps
module serial_flash_port_tb;
   import flash_port_pkg::*;
   localparam logic [31:0] PAT = 32'hC3A5_5A3C;
   logic sys_clk, linkClk, rst_b, cmdValid, cmdReady, rdDone, flashClk, flashSelectN, flashDout, flashDin;
   logic [31:0] rdData, seed;
   logic [95:0] rxBits;
   logic [6:0]  rxCnt;
   flash_cmd_t  cmd;
   int          error_cnt, n_compared, cyc;
   serial_flash_port u_dut (.sys_clk(sys_clk), .linkClk(linkClk), .rst_b(rst_b), .cmdValid(cmdValid), .cmd(cmd),
      .cmdReady(cmdReady), .rdDone(rdDone), .rdData(rdData), .flashClk(flashClk), .flashSelectN(flashSelectN),
      .flashDout(flashDout), .flashDin(flashDin));
   flash_model #(.PAT(PAT)) u_flash (.flashClk(flashClk), .flashSelectN(flashSelectN), .flashDout(flashDout),
      .flashDin(flashDin), .rxBits(rxBits), .rxCnt(rxCnt));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      linkClk = 1'b0;
      #1.7;
      forever #3 linkClk = ~linkClk;
   end
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [95:0] expTx(flash_cmd_t c);
      logic [95:0] e;
      e = {88'h0, c.opcode};
      if (c.hasAddr) e = {e[71:0], c.address};
      for (int i = 0; i < c.wrBytes; i++) e = {e[87:0], c.wrData[31 - 8 * i -: 8]};
      return e << (8 * c.rdBytes);
   endfunction : expTx
   function automatic logic [31:0] expRd(int n, int r);
      logic [31:0] d;
      d = '0;
      for (int j = 0; j < r; j++) d = {d[30:0], PAT[31 - ((n - r + j) % 32)]};
      return d;
   endfunction : expRd
   task automatic check(logic [95:0] seen, logic [95:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic results();
      $display("compared %0d mismatched %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // ----------------------------------------
   // one transfer; refuse keeps offering while busy
   // ----------------------------------------
   task automatic run(flash_cmd_t c, bit refuse);
      int n, r, k;
      logic [95:0] m;
      r = 8 * c.rdBytes;
      n = 8 + (c.hasAddr ? 24 : 0) + 8 * c.wrBytes + r;
      m = (96'h1 << r) - 96'h1;
      k = 0;
      cmd <= c;
      cmdValid <= 1'b1;
      @(posedge sys_clk);
      @(posedge sys_clk);
      repeat (refuse ? 6 : 0) @(posedge sys_clk);
      cmdValid <= 1'b0;
      while (rdDone !== 1'b1 && k < 20000) begin
         @(negedge sys_clk);
         k++;
      end
      check(96'(rdData) & m, 96'(expRd(n, 8 * c.rdBytes)));
      check(96'(rxCnt), 96'(n));
      check(rxBits & ~m, expTx(c));
      repeat (3) @(posedge sys_clk);
      check({cmdReady, flashSelectN}, 96'h3);
      $display("test done, %0d bits", n);
   endtask : run
   always @(posedge sys_clk) if (++cyc == 40000) begin
      error_cnt++;
      results();
   end
   initial begin
      rst_b = 1'b0;
      cmdValid = 1'b0;
      cmd = '0;
      seed = 32'h43;
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      run('{8'h03, 24'hFF_FFFF, 1'b1, 32'h0, 3'h0, 3'h4, 8'h00}, 0);
      run('{8'h9F, 24'h0, 1'b0, 32'h0, 3'h0, 3'h3, 8'hC8}, 0);
      run('{8'h02, 24'h00_0000, 1'b1, 32'hA55A_0FF0, 3'h4, 3'h0, 8'h03}, 1);
      for (int t = 0; t < 6; t++) begin
         seed = lfsr(seed);
         run('{seed[31:24], seed[23:0], seed[5], lfsr(seed), 3'(seed[7:0] % 5), 3'(seed[15:8] % 5),
               8'h03 + 8'(seed[2:0])}, 0);
      end
      results();
   end
endmodule : serial_flash_port_tb
